// [rtl/rcm_selector.sv]
// Purpose: four-input reference clock monitor with priority selection
// Assumes: clk_i 40 MHz; ref inputs pre-synchronised samples; ticks are
//          one-cycle pulses from the loss-detect divider and the VCXO path
// Notes: registers on classic wishbone; unmapped reads return zero
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.

module rcm_selector #(
    parameter int FREQ_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // reference inputs
    input wire logic [3:0] ref_clk_i,
    input wire logic [3:0] ref_diff_zero_i,
    input wire logic los_tick_i,
    input wire logic vcxo_tick_i,
    input wire logic [FREQ_W-1:0] freq_word_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // selection outputs
    output logic [1:0] active_sel_o,
    output logic holdover_o,
    output logic [FREQ_W-1:0] hold_freq_o
);
    localparam int N = rcm_pkg::NUM_INPUTS;

    logic rst_s1, rst_n;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end

    // configuration
    logic [1:0] selection_mode, manual_sel;
    logic revertive_enable, monitor_flag_block;
    logic [7:0] revalidation_count, holdoff_start_value;
    logic [23:0] holdoff_prescaler;
    logic [1:0] prio [N];
    logic [3:0] input_live_status, input_sticky_los;
    logic ref_live_status, ref_sticky_status;
    logic [1:0] sel;
    logic hold;

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    wire wr_ctrl = wb_wr && wb_adr_i == rcm_pkg::OFS_CTRL;
    wire wr_prio = wb_wr && wb_adr_i == rcm_pkg::OFS_PRIO;
    wire wr_hold = wb_wr && wb_adr_i == rcm_pkg::OFS_HOLD;
    wire wr_sticky = wb_wr && wb_adr_i == rcm_pkg::OFS_STICKY;

    always_ff @(posedge clk_i or negedge rst_n)
        if (!rst_n)
        begin
            selection_mode <= 2'h0;
            manual_sel <= 2'h0;
            revertive_enable <= 1'b0;
            monitor_flag_block <= 1'b0;
            revalidation_count <= rcm_pkg::REVALIDATION_COUNT_RST;
            holdoff_start_value <= rcm_pkg::HOLD_START_RST;
            holdoff_prescaler <= rcm_pkg::PRESC_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                selection_mode <= wb_dat_i[rcm_pkg::CTRL_MODE_LSB +: 2];
                manual_sel <= wb_dat_i[rcm_pkg::CTRL_SEL_LSB +: 2];
                revertive_enable <= wb_dat_i[rcm_pkg::CTRL_REVERTIVE_ENABLE];
                monitor_flag_block <= wb_dat_i[rcm_pkg::CTRL_BLOCK];
                revalidation_count <= wb_dat_i[rcm_pkg::CTRL_REVALIDATION_COUNT_LSB +: 8];
            end
            if (wr_hold)
            begin
                holdoff_start_value <= wb_dat_i[rcm_pkg::HOLD_START_LSB +: 8];
                holdoff_prescaler <= wb_dat_i[rcm_pkg::HOLD_PRESC_LSB +: 24];
            end
        end

    // priorities may change at any time
    always_ff @(posedge clk_i or negedge rst_n)
        if (!rst_n)
            for (int i = 0; i < N; i++)
                prio[i] <= 2'h0;
        else if (wr_prio)
            for (int i = 0; i < N; i++)
                prio[i] <= wb_dat_i[2*i +: 2];

    // per-input activity monitor
    logic [3:0] loss_evt, reval_evt;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mon
            logic prev, armed;
            logic [1:0] miss;
            logic [7:0] good;
            wire edge_seen = ref_clk_i[g] && !prev && !ref_diff_zero_i[g];
            always_ff @(posedge clk_i or negedge rst_n)
                if (!rst_n)
                begin
                    prev <= 1'b0;
                    miss <= 2'h0;
                    good <= 8'h00;
                    armed <= 1'b1;
                    input_live_status[g] <= 1'b0;
                    input_sticky_los[g] <= 1'b0;
                end
                else
                begin
                    prev <= ref_clk_i[g];
                    // a static input never produces edge_seen
                    if (edge_seen)
                        miss <= 2'h0;
                    else if (los_tick_i && miss != 2'(rcm_pkg::LOSS_EDGES))
                        miss <= miss + 2'h1;
                    if (loss_evt[g])
                    begin
                        input_live_status[g] <= 1'b0;
                        good <= 8'h00;
                        if (!monitor_flag_block)
                        begin
                            input_sticky_los[g] <= 1'b1;
                            armed <= 1'b0;
                        end
                    end
                    else if (!input_live_status[g] && edge_seen)
                    begin
                        if (good + 8'h01 >= revalidation_count)
                            input_live_status[g] <= 1'b1;
                        good <= good + 8'h01;
                    end
                    // clear by writing 1 only after revalidation
                    if (wr_sticky && wb_dat_i[g] && input_live_status[g]
                        && !loss_evt[g])
                    begin
                        input_sticky_los[g] <= 1'b0;
                        armed <= 1'b1;
                    end
                end
            // missed edges or zero differential, once re-armed
            assign loss_evt[g] = input_live_status[g] && armed &&
                ((los_tick_i && !edge_seen &&
                  miss == 2'(rcm_pkg::LOSS_EDGES - 1)) || ref_diff_zero_i[g]);
            assign reval_evt[g] = !input_live_status[g] && edge_seen &&
                good + 8'h01 >= revalidation_count && !ref_diff_zero_i[g];
        end
    endgenerate

    // highest-priority valid input, lowest index on ties
    logic [1:0] best;
    logic best_ok;
    wire [3:0] cand = input_live_status | reval_evt;
    wire none_live = input_live_status == 4'h0;
    always_comb
    begin
        best = 2'h0;
        best_ok = 1'b0;
        for (int i = N - 1; i >= 0; i--)
            if (cand[i] && (!best_ok || prio[i] >= prio[best]))
            begin
                best = 2'(i);
                best_ok = 1'b1;
            end
    end

    // hold-off prescaler and counter
    logic [23:0] presc;
    logic [7:0] hcnt;
    logic expire;
    wire hold_run = selection_mode == rcm_pkg::MODE_AUTO_HOLD && hold;
    always_ff @(posedge clk_i or negedge rst_n)
        if (!rst_n)
        begin
            presc <= 24'h000000;
            hcnt <= rcm_pkg::HOLD_START_RST;
            expire <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (!hold_run) // prescaler held at zero outside
            begin
                presc <= 24'h000000;
                hcnt <= holdoff_start_value;
            end
            else if (hcnt == 8'h00)
            begin
                expire <= 1'b1;
                hcnt <= holdoff_start_value;
            end
            else if (vcxo_tick_i)
            begin
                if (presc + 24'h000001 >= holdoff_prescaler)
                begin
                    presc <= 24'h000000;
                    hcnt <= hcnt - 8'h01;
                end
                else
                    presc <= presc + 24'h000001;
            end
        end

    // selection state machine
    wire sel_live = input_live_status[sel];
    wire sel_lost = loss_evt[sel];
    always_ff @(posedge clk_i or negedge rst_n)
        if (!rst_n)
        begin
            sel <= 2'h0;
            hold <= 1'b0;
            ref_live_status <= 1'b0;
            ref_sticky_status <= 1'b0;
        end
        else
        begin
            unique case (rcm_pkg::rcm_mode_t'(selection_mode))
                rcm_pkg::MODE_MANUAL:
                begin
                    sel <= manual_sel;
                    hold <= 1'b0;
                    ref_live_status <= input_live_status[manual_sel];
                end
                rcm_pkg::MODE_SHORT_HOLD:
                begin
                    sel <= manual_sel;
                    if (loss_evt[manual_sel])
                    begin
                        hold <= 1'b1;
                        ref_live_status <= 1'b0;
                        ref_sticky_status <= 1'b0;
                    end
                    else if (input_live_status[manual_sel])
                    begin
                        hold <= 1'b0;
                        ref_live_status <= 1'b1;
                    end
                end
                rcm_pkg::MODE_AUTO:
                begin
                    hold <= 1'b0;
                    if (!sel_live || sel_lost)
                    begin
                        // switch at once, or wait for any revalidated
                        if (best_ok && !loss_evt[best])
                            sel <= best;
                    end
                    else if (revertive_enable && best_ok &&
                             prio[best] > prio[sel])
                        sel <= best;
                    ref_live_status <= sel_live && !sel_lost;
                end
                rcm_pkg::MODE_AUTO_HOLD:
                begin
                    if (sel_lost)
                    begin
                        hold <= 1'b1;
                        ref_live_status <= 1'b0;
                        ref_sticky_status <= 1'b0;
                    end
                    else if (expire || (hold && none_live && |reval_evt))
                    begin
                        // keep recovered ref, else best, else stay
                        if (sel_live)
                        begin
                            hold <= 1'b0;
                            ref_live_status <= 1'b1;
                        end
                        else if (best_ok)
                        begin
                            sel <= best;
                            hold <= 1'b0;
                            ref_live_status <= 1'b1;
                        end
                    end
                    else if (!hold && revertive_enable && best_ok &&
                             prio[best] > prio[sel])
                        sel <= best;
                end
            endcase
            if (wr_sticky && wb_dat_i[rcm_pkg::SK_REF] && ref_live_status
                && !sel_lost)
                ref_sticky_status <= 1'b1;
        end

    // holdover value: frozen frequency word while in holdover
    always_ff @(posedge clk_i or negedge rst_n)
        if (!rst_n)
        begin
            hold_freq_o <= '0;
            active_sel_o <= 2'h0;
            holdover_o <= 1'b0;
        end
        else
        begin
            if (!hold)
                hold_freq_o <= freq_word_i;
            active_sel_o <= sel;
            holdover_o <= hold;
        end

    // wishbone answer: one wait-free cycle, unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_n)
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i)
                unique case (wb_adr_i)
                    rcm_pkg::OFS_CTRL:
                        wb_dat_o <= {16'h0000, revalidation_count, 2'h0,
                                     monitor_flag_block, revertive_enable,
                                     manual_sel, selection_mode};
                    rcm_pkg::OFS_PRIO:
                        wb_dat_o <= {24'h000000, prio[3], prio[2], prio[1],
                                     prio[0]};
                    rcm_pkg::OFS_HOLD:
                        wb_dat_o <= {holdoff_prescaler, holdoff_start_value};
                    rcm_pkg::OFS_STATUS:
                        wb_dat_o <= {24'h000000, hold, ref_live_status, sel,
                                     input_live_status};
                    rcm_pkg::OFS_STICKY:
                        wb_dat_o <= {27'h0000000, ref_sticky_status,
                                     input_sticky_los};
                    default:
                        wb_dat_o <= 32'h00000000;
                endcase
        end

    // checks
    chk_manual_follow: assert property (selection_mode == 2'h0
        |=> sel == $past(manual_sel))
        else $error("manual mode selection mismatch");
    chk_short_hold: assert property (selection_mode == 2'h2
        && loss_evt[manual_sel] |=> hold && !ref_live_status)
        else $error("short holdover not entered");
    chk_auto_nohold: assert property (selection_mode == 2'h1 |=> !hold)
        else $error("holdover in plain automatic mode");
    chk_presc_idle: assert property (!hold_run |=> presc == 24'h0)
        else $error("prescaler ran outside hold");
    chk_mode11_hold: assert property (selection_mode == 2'h3
        && sel_lost |=> hold && $stable(sel))
        else $error("mode 11 loss handling wrong");
    chk_revertive_enable_off: assert property (selection_mode[0] && !hold
        && !revertive_enable && sel_live && !sel_lost |=> $stable(sel))
        else $error("non-revertive switch");
    chk_sticky_clr: assert property ($fell(input_sticky_los[0])
        |-> $past(input_live_status[0]))
        else $error("sticky cleared before revalidation");
    chk_block_flag: assert property (monitor_flag_block
        |=> (input_sticky_los & ~$past(input_sticky_los)) == 4'h0)
        else $error("flag raised while blocked");
endmodule // rcm_selector

// [rtl/rcm_pkg.sv]
// Purpose: shared constants for the reference clock monitor and selector
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: register offsets are word aligned
package rcm_pkg;
    localparam int NUM_INPUTS = 4;
    localparam int LOSS_EDGES = 3;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRIO = 8'h04;
    localparam logic [7:0] OFS_HOLD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_STICKY = 8'h10;
    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SEL_LSB = 2;
    localparam int CTRL_REVERTIVE_ENABLE = 4;
    localparam int CTRL_BLOCK = 5;
    localparam int CTRL_REVALIDATION_COUNT_LSB = 8;
    localparam int REVALIDATION_COUNT_W = 8;
    localparam logic [7:0] REVALIDATION_COUNT_RST = 8'h04;
    // hold fields
    localparam int HOLD_START_LSB = 0;
    localparam int HOLD_PRESC_LSB = 8;
    localparam int PRESC_W = 24;
    localparam logic [7:0] HOLD_START_RST = 8'hFF;
    localparam logic [23:0] PRESC_RST = 24'h020000;
    // status fields
    localparam int ST_INPUT_LSB = 0;
    localparam int ST_SEL_LSB = 4;
    localparam int REF_LIVE_STATUS_LIVE = 6;
    localparam int ST_HOLDOVER = 7;
    // sticky fields
    localparam int SK_INPUT_LSB = 0;
    localparam int SK_REF = 4;
    typedef enum logic [1:0]
    {
        MODE_MANUAL = 2'h0,
        MODE_AUTO = 2'h1,
        MODE_SHORT_HOLD = 2'h2,
        MODE_AUTO_HOLD = 2'h3
    } rcm_mode_t;
endpackage

// [testbench/rcm_ref_source.sv]
// Purpose: behavioural model of the four redundant reference clock sources
// Assumes: bench clock of 40 MHz; each source divides it down
// Notes: slow_i doubles every period; a halted source holds its level
module rcm_ref_source
(
    // clock
    input wire logic clk_i,
    // control from the bench
    input wire logic [3:0] run_i,
    input wire logic slow_i,
    // reference outputs
    output logic [3:0] ref_clk_o = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase = 3'h0;
    always_ff @(posedge clk_i)
    begin
        phase <= phase + 3'h1;
    end
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < 4; i++)
        begin
            // a failed source goes static, never wanders
            if (run_i[i])
                ref_clk_o[i] <= slow_i ? phase[2] : phase[1];
        end
    end
endmodule // rcm_ref_source

// [testbench/rcm_selector_test.sv]
// Purpose: self-checking bench for the reference monitor and selector
// Assumes: classic wishbone master; bench-made reference and vcxo ticks
// Notes: hold-off shortened through the hold register to keep runs short
module rcm_selector_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_n_i = 0, slow = 0, los_tick = 0, vcxo_tick = 0;
    logic cyc = 0, stb = 0, we = 0, hold, ack;
    logic [3:0] run = 4'hF, diffz = 4'h0, ref_clk;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0, dr, s;
    logic [15:0] freq = 16'h0000, hfreq, f;
    logic [1:0] asel, a;
    int n_fail = 0, check_count = 0, tk = 0;
    int pr [4] = '{2, 3, 3, 0};
    always #12.5 clk_i = ~clk_i;
    // loss ticks matched to the slow source rate, which software must arrange
    always @(posedge clk_i)
    begin
        tk <= tk + 1;
        los_tick <= (tk % 8 == 7);
        vcxo_tick <= (tk % 4 == 3);
        freq <= freq + 16'h0001;
        if (tk == 30000)
        begin
            n_fail++;
            end_of_test;
        end
    end
    rcm_ref_source src (.clk_i(clk_i), .run_i(run), .slow_i(slow),
        .ref_clk_o(ref_clk));
    rcm_selector uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ref_clk_i(ref_clk),
        .ref_diff_zero_i(diffz), .los_tick_i(los_tick),
        .vcxo_tick_i(vcxo_tick), .freq_word_i(freq), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .active_sel_o(asel),
        .holdover_o(hold), .hold_freq_o(hfreq));
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= ad;
        dw <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        s = dr;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        acc(1'b1, ad, d);
    endtask
    task rd(input logic [7:0] ad);
        acc(1'b0, ad, 32'h0);
    endtask
    task wait_st(input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 150; i++)
        begin
            rd(rcm_pkg::OFS_STATUS);
            if ((s & m) === v)
                break;
        end
        chk("status", v, s & m);
    endtask
    task setrun(input logic [3:0] v);
        @(posedge clk_i);
        run <= v;
    endtask
    task clr;
        wr(rcm_pkg::OFS_STICKY, 32'h0000001F);
    endtask
    function automatic logic [31:0] cw(input logic [1:0] m,
        input logic [1:0] sl, input logic r, input logic b);
        return {16'h0000, 8'h04, 2'b00, b, r, sl, m};
    endfunction
    function automatic logic [1:0] best(input logic [3:0] v);
        int bp;
        logic [1:0] b;
        bp = -1;
        b = 2'h0;
        for (int i = 0; i < 4; i++)
            if (v[i] && pr[i] > bp)
            begin
                bp = pr[i];
                b = 2'(i);
            end
        return b;
    endfunction
    task t_regs;
        rd(rcm_pkg::OFS_CTRL);
        chk("ctrl", 32'h00000400, s);
        rd(rcm_pkg::OFS_PRIO);
        chk("prio", 32'h00000000, s);
        rd(rcm_pkg::OFS_HOLD);
        chk("hold", 32'h020000FF, s);
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14);
        chk("unmapped", 32'h00000000, s);
        wait_st(32'hF, 32'hF);
        clr;
        slow <= 1;
        repeat (200) @(posedge clk_i);
        rd(rcm_pkg::OFS_STICKY);
        chk("slow sticky", 32'h0, s & 32'hF);
        slow <= 0;
        $display("test regs done");
    endtask
    task t_manual;
        wr(rcm_pkg::OFS_CTRL, cw(2'h0, 2'h2, 1'b0, 1'b0));
        clr;
        setrun(4'hB);
        wait_st(32'h4, 32'h0);
        rd(rcm_pkg::OFS_STICKY);
        chk("sticky loss", 32'h4, s & 32'h4);
        chk("sel", 32'h2, {30'h0, asel});
        wr(rcm_pkg::OFS_STICKY, 32'h4);
        rd(rcm_pkg::OFS_STICKY);
        chk("early clear", 32'h4, s & 32'h4);
        setrun(4'hF);
        wait_st(32'h4, 32'h4);
        chk("sel kept", 32'h2, {30'h0, asel});
        setrun(4'hB);
        repeat (60) @(posedge clk_i);
        rd(rcm_pkg::OFS_STATUS);
        chk("not rearmed", 32'h4, s & 32'h4);
        setrun(4'hF);
        wr(rcm_pkg::OFS_STICKY, 32'h4);
        rd(rcm_pkg::OFS_STICKY);
        chk("clear", 32'h0, s & 32'h4);
        diffz <= 4'h8;
        wait_st(32'h8, 32'h0);
        diffz <= 4'h0;
        wait_st(32'h8, 32'h8);
        clr;
        wr(rcm_pkg::OFS_CTRL, cw(2'h0, 2'h2, 1'b0, 1'b1));
        setrun(4'hE);
        wait_st(32'h1, 32'h0);
        rd(rcm_pkg::OFS_STICKY);
        chk("blocked sticky", 32'h0, s & 32'h1);
        setrun(4'hF);
        wait_st(32'h1, 32'h1);
        $display("test manual done");
    endtask
    task t_auto;
        wr(rcm_pkg::OFS_CTRL, cw(2'h0, 2'h1, 1'b0, 1'b0));
        clr;
        wr(rcm_pkg::OFS_PRIO, 32'h0000003E);
        wr(rcm_pkg::OFS_CTRL, cw(2'h1, 2'h1, 1'b0, 1'b0));
        setrun(4'h9);
        wait_st(32'h30, 32'h00);
        chk("no holdover", 32'h0, {31'h0, hold});
        setrun(4'hB);
        wait_st(32'h2, 32'h2);
        chk("non revert", 32'h0, {30'h0, asel});
        setrun(4'hF);
        wait_st(32'h4, 32'h4);
        clr;
        wr(rcm_pkg::OFS_CTRL, cw(2'h1, 2'h1, 1'b1, 1'b0));
        setrun(4'hE);
        wait_st(32'h30, 32'h10);
        setrun(4'hF);
        wait_st(32'h1, 32'h1);
        chk("lower no revert", 32'h1, {30'h0, asel});
        clr;
        setrun(4'h9);
        wait_st(32'h30, 32'h00);
        setrun(4'hD);
        wait_st(32'h30, 32'h20);
        clr;
        setrun(4'h0);
        wait_st(32'hF, 32'h0);
        chk("none valid", 32'h2, {29'h0, hold, asel});
        setrun(4'h8);
        wait_st(32'h30, 32'h30);
        setrun(4'hF);
        wait_st(32'hF, 32'hF);
        clr;
        $display("test auto done");
    endtask
    task t_short;
        wr(rcm_pkg::OFS_CTRL, cw(2'h2, 2'h0, 1'b0, 1'b0));
        clr;
        setrun(4'hE);
        wait_st(32'hC0, 32'h80);
        chk("sel", 32'h0, {30'h0, asel});
        rd(rcm_pkg::OFS_STICKY);
        chk("ref sticky", 32'h0, s & 32'h10);
        f = hfreq;
        repeat (20) @(posedge clk_i);
        chk("frozen freq", {16'h0, f}, {16'h0, hfreq});
        setrun(4'hF);
        wait_st(32'hF0, 32'h40);
        clr;
        $display("test short holdover done");
    endtask
    task t_hold;
        wr(rcm_pkg::OFS_HOLD, {24'h000002, 8'h20});
        wr(rcm_pkg::OFS_CTRL, cw(2'h3, 2'h0, 1'b0, 1'b0));
        clr;
        rd(rcm_pkg::OFS_STATUS);
        a = s[5:4];
        setrun(4'hF & ~(4'h1 << a));
        wait_st(32'h80, 32'h80);
        repeat (100) @(posedge clk_i);
        chk("held sel", {30'h0, a}, {30'h0, asel});
        wait_st(32'hF0, {24'h0, 2'b01, best(4'hF & ~(4'h1 << a)), 4'h0});
        setrun(4'hF);
        wait_st(32'hF, 32'hF);
        clr;
        a = asel;
        setrun(4'hF & ~(4'h1 << a));
        wait_st(32'h80, 32'h80);
        setrun(4'hF);
        wait_st(32'hF0, {24'h0, 2'b01, a, 4'h0});
        clr;
        setrun(4'h0);
        wait_st(32'h8F, 32'h80);
        repeat (300) @(posedge clk_i);
        chk("stay holdover", 32'h1, {31'h0, hold});
        setrun(4'h4);
        wait_st(32'hF0, 32'h60);
        setrun(4'hF);
        $display("test auto holdover done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (4) @(posedge clk_i);
        t_regs;
        t_manual;
        t_auto;
        t_short;
        t_hold;
        end_of_test;
    end
endmodule // rcm_selector_test
